// [verilog/hio_pkg.sv]
// Constants for the host I/O control and status port.
package hio_pkg;

  localparam int HIO_W = 36;

  // Host bit n sits at vector index (35 - n)
  localparam int HIO_MSB = 35;

  // Device select: 7-bit code, i.e. the 9-bit device number over four
  localparam logic [6:0] DEV_DISPLAY = 7'h16; // Device 130 (octal)
  localparam logic [6:0] DEV_MAPPER  = 7'h17; // Device 134 (octal)

  // Control word bit numbers (host numbering, bit 0 is the MSB)
  localparam int CO_SYS_CLEAR  = 18;
  localparam int CO_ALARM_ON   = 19;
  localparam int CO_ALARM_OFF  = 20;
  localparam int CO_MAP_ON     = 22;
  localparam int CO_MAP_OFF    = 23;
  localparam int CO_IOSTOP_SET = 24;
  localparam int CO_STOPI_ON   = 25;
  localparam int CO_STOPI_OFF  = 26;
  localparam int CO_IOSTOP_CLR = 27;
  localparam int CO_PSTOP_CLR  = 28;
  localparam int CO_HIT_CLR    = 29;
  localparam int CO_STEP       = 30;
  localparam int CO_PI_ALLOW   = 32;
  localparam int CO_PI_LSB     = 35;

  // Status word bit numbers
  localparam int CI_FLAG0      = 0;
  localparam int CI_FLAG3      = 3;
  localparam int CI_PARITY     = 18;
  localparam int CI_NONEX      = 19;
  localparam int CI_ALARM_EN   = 20;
  localparam int CI_MAP_VIOL   = 21;
  localparam int CI_MAP_EN     = 22;
  localparam int CI_STOP_RDY   = 24;
  localparam int CI_STOPI_EN   = 25;
  localparam int CI_MM_STOP    = 26;
  localparam int CI_IO_STOP    = 27;
  localparam int CI_PROG_STOP  = 28;
  localparam int CI_HIT_STOP   = 29;
  localparam int CI_SCOPE_STOP = 30;
  localparam int CI_IRQ        = 32;
  localparam int CI_PI_LSB     = 35;

  localparam int PI_W      = 3;
  localparam int PI_LINES  = 7;
  localparam logic [PI_W-1:0] PI_RESET = 3'h0;

  // Vector index of host bit n
  function automatic int hio_idx(input int n);
    return HIO_MSB - n;
  endfunction

endpackage

// [verilog/hio_pi_decode.sv]
// One-of-seven decode of the assigned priority level onto interrupt lines.
module hio_pi_decode
  import hio_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [PI_W-1:0]     level,
  input  wire logic                request,
  input  wire logic                line_enable_n,
  output logic      [PI_LINES:1]   lines_out
);

  logic [PI_LINES:1] next_lines;

  always_comb begin
    next_lines = '0;
    // Level zero means unassigned: no line is chosen
    if (request && !line_enable_n && level != PI_RESET) begin
      next_lines[level] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lines_out <= '0;
    end else begin
      lines_out <= next_lines;
    end
  end

endmodule

// [verilog/hio_port.sv]
// Host I/O bus control and status port of the display channel processor.
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Control write with bit 32 set loads host bits 33-35 into the priority level flops.
// - Level decodes one of seven lines, driven only while line enable low.
// - Device select code 130 is the display, code 134 the mapper.
// - Display select is qualified by five strobes (not control clear), mapper only by data set, data clear and DATAI.
// - Status read to the display puts the status word on the bus.
// - Bit 18 clears processor and clipper, stop state, no data lost.
// - Bit 19 enables, bit 20 disables the memory alarm interrupt.
// - Bit 22 enables, bit 23 disables the map/protect interrupt.
// - Bit 24 sets, 27 clears I/O stop; 25/26 enable/disable stop irq.
// - Bit 28 clears program stop, 29 clears hit, 30 steps once.
// - Bit 32 allows a new priority level from bits 33-35.
// - Status bits 18-22 report alarms, violation and their enables.
// - Status 24 stopped-ready, 25 stop irq on, 26-30 stop causes.
// - Status 32 shows an interrupt raised, 33-35 the assigned level.
module hio_port
  import hio_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RESET_N,
  // Host I/O bus
  input  wire logic [6:0]         DEVICE_SELECT_BITS,
  input  wire logic [HIO_W-1:0]   HOST_DATA_IN,
  output logic      [HIO_W-1:0]   HOST_DATA_OUT,
  output logic                    HOST_DATA_OE,
  input  wire logic               DATAO_SET,
  input  wire logic               DATAO_CLR,
  input  wire logic               CONTROL_SET,
  input  wire logic               CONTROL_CLR,
  input  wire logic               DATAI,
  input  wire logic               STATUS_READ,
  input  wire logic               INTERRUPT_LINE_ENABLE_N,
  output logic      [PI_LINES:1]  PI_REQ,
  // Processor side
  output logic      [HIO_W-1:0]   DATA_WORD,
  output logic                    DISPLAY_DATA_STB,
  output logic                    MAPPER_DATA_STB,
  input  wire logic [HIO_W-1:0]   DISPLAY_READ_WORD,
  input  wire logic [HIO_W-1:0]   MAPPER_READ_WORD,
  output logic                    SYSTEM_CLEAR,
  output logic                    STEP,
  output logic                    IO_STOP,
  input  wire logic [3:0]         PROGRAM_FLAGS,
  input  wire logic               PARITY_ERROR,
  input  wire logic               NONEXISTENT_MEMORY,
  input  wire logic               MAP_VIOLATION,
  input  wire logic               STOPPED_READY,
  input  wire logic               MM_STOP,
  input  wire logic               PROGRAM_STOP,
  input  wire logic               HIT,
  input  wire logic               SCOPE_VIOLATION
);

  //////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on every host pin
  localparam int SYN_W = 7 + HIO_W + 7;

  logic [SYN_W-1:0] sync_a;
  logic [SYN_W-1:0] sync_b;
  logic [5:0]       strobe_d;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {DEVICE_SELECT_BITS, HOST_DATA_IN, DATAO_SET, DATAO_CLR,
                 CONTROL_SET, CONTROL_CLR, DATAI, STATUS_READ,
                 INTERRUPT_LINE_ENABLE_N};
      sync_b <= sync_a;
    end
  end

  logic [6:0]       sel;
  logic [HIO_W-1:0] hdata;
  logic [5:0]       strobe;
  logic             line_en_n;

  assign sel       = sync_b[SYN_W-1 -: 7];
  assign hdata     = sync_b[7 +: HIO_W];
  assign strobe    = sync_b[6:1];
  assign line_en_n = sync_b[0];

  // Write strobes act once, on their rising edge after synchronisation; DATAI and status read act on level
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      strobe_d <= '0;
    end else begin
      strobe_d <= strobe;
    end
  end

  logic [5:0] rise;
  logic       is_disp;
  logic       is_map;

  assign rise    = strobe & ~strobe_d;
  assign is_disp = (sel == DEV_DISPLAY);
  assign is_map  = (sel == DEV_MAPPER);

  // rise: 5 data set, 4 data clr, 3 ctrl set, 2 ctrl clr, 1 DATAI, 0 status
  logic do_set_d;
  logic do_set_m;
  logic do_clr_d;
  logic do_clr_m;
  logic co_wr;
  logic di_d;
  logic di_m;
  logic ci_d;

  assign do_set_d = rise[5] & is_disp;
  assign do_set_m = rise[5] & is_map;
  assign do_clr_d = rise[4] & is_disp;
  assign do_clr_m = rise[4] & is_map;
  assign co_wr    = rise[3] & is_disp;
  assign di_d     = strobe[1] & is_disp;
  assign di_m     = strobe[1] & is_map;
  assign ci_d     = strobe[0] & is_disp;

  // Clear-then-set transfers; only the set edge strobes the processor
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      DATA_WORD        <= '0;
      DISPLAY_DATA_STB <= 1'b0;
      MAPPER_DATA_STB  <= 1'b0;
    end else begin
      DISPLAY_DATA_STB <= do_set_d;
      MAPPER_DATA_STB  <= do_set_m;
      if (do_clr_d || do_clr_m) begin
        DATA_WORD <= '0;
      end else if (do_set_d || do_set_m) begin
        DATA_WORD <= DATA_WORD | hdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control word decode; the control clear strobe has no bits to act on
  function automatic logic cbit(input logic [HIO_W-1:0] w, input int n);
    return w[hio_idx(n)];
  endfunction

  logic [PI_W-1:0] pi_level;
  logic            alarm_en;
  logic            map_en;
  logic            stopi_en;
  logic            parity_f;
  logic            nonex_f;
  logic            viol_f;
  logic            prog_f;
  logic            hit_f;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pi_level <= PI_RESET;
    end else if (co_wr && cbit(hdata, CO_PI_ALLOW)) begin
      pi_level <= hdata[hio_idx(CO_PI_LSB) +: PI_W];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      SYSTEM_CLEAR <= 1'b0;
      STEP         <= 1'b0;
    end else begin
      // One-cycle pulses; the processor keeps its registers on clear
      SYSTEM_CLEAR <= co_wr & cbit(hdata, CO_SYS_CLEAR);
      STEP         <= co_wr & cbit(hdata, CO_STEP);
    end
  end

  // Enable and disable in one write: disable wins, the safer outcome
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      alarm_en <= 1'b0;
      map_en   <= 1'b0;
      stopi_en <= 1'b0;
    end else if (co_wr) begin
      if (cbit(hdata, CO_ALARM_OFF)) begin
        alarm_en <= 1'b0;
      end else if (cbit(hdata, CO_ALARM_ON)) begin
        alarm_en <= 1'b1;
      end
      if (cbit(hdata, CO_MAP_OFF)) begin
        map_en <= 1'b0;
      end else if (cbit(hdata, CO_MAP_ON)) begin
        map_en <= 1'b1;
      end
      if (cbit(hdata, CO_STOPI_OFF)) begin
        stopi_en <= 1'b0;
      end else if (cbit(hdata, CO_STOPI_ON)) begin
        stopi_en <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IO_STOP <= 1'b0;
    end else if (co_wr && cbit(hdata, CO_IOSTOP_CLR)) begin
      IO_STOP <= 1'b0;
    end else if (co_wr && cbit(hdata, CO_IOSTOP_SET)) begin
      IO_STOP <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky causes: a new event in the clearing cycle keeps the flag set
  logic clr_sys;
  logic clr_prog;
  logic clr_hit;

  assign clr_sys  = co_wr & cbit(hdata, CO_SYS_CLEAR);
  assign clr_prog = co_wr & cbit(hdata, CO_PSTOP_CLR);
  assign clr_hit  = co_wr & cbit(hdata, CO_HIT_CLR);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      parity_f <= 1'b0;
      nonex_f  <= 1'b0;
      viol_f   <= 1'b0;
      prog_f   <= 1'b0;
      hit_f    <= 1'b0;
    end else begin
      parity_f <= PARITY_ERROR | (parity_f & ~clr_sys);
      nonex_f  <= NONEXISTENT_MEMORY | (nonex_f & ~clr_sys);
      viol_f   <= MAP_VIOLATION | (viol_f & ~clr_sys);
      prog_f   <= PROGRAM_STOP | (prog_f & ~clr_prog & ~clr_sys);
      hit_f    <= HIT | (hit_f & ~clr_hit & ~clr_sys);
    end
  end

  logic irq;

  assign irq = (alarm_en & (parity_f | nonex_f))
             | (map_en & viol_f)
             | (stopi_en & STOPPED_READY);

  hio_pi_decode hio_pi_decode_i (
    .clk           (CLK),
    .reset_n       (RESET_N),
    .level         (pi_level),
    .request       (irq),
    .line_enable_n (line_en_n),
    .lines_out     (PI_REQ)
  );

  //////////////////////////////////////////////////////////////////////////
  // Status word, assembled in host numbering; unlisted bits stay zero
  logic [HIO_W-1:0] status;

  always_comb begin
    status = '0;
    status[hio_idx(CI_FLAG3) +: 4] = PROGRAM_FLAGS;
    status[hio_idx(CI_PARITY)]     = parity_f;
    status[hio_idx(CI_NONEX)]      = nonex_f;
    status[hio_idx(CI_ALARM_EN)]   = alarm_en;
    status[hio_idx(CI_MAP_VIOL)]   = viol_f;
    status[hio_idx(CI_MAP_EN)]     = map_en;
    status[hio_idx(CI_STOP_RDY)]   = STOPPED_READY;
    status[hio_idx(CI_STOPI_EN)]   = stopi_en;
    status[hio_idx(CI_MM_STOP)]    = MM_STOP;
    status[hio_idx(CI_IO_STOP)]    = IO_STOP;
    status[hio_idx(CI_PROG_STOP)]  = prog_f;
    status[hio_idx(CI_HIT_STOP)]   = hit_f;
    status[hio_idx(CI_SCOPE_STOP)] = SCOPE_VIOLATION;
    status[hio_idx(CI_IRQ)]        = |PI_REQ;
    status[hio_idx(CI_PI_LSB) +: PI_W] = pi_level;
  end

  // Bus drive held as long as the read strobe stays up
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      HOST_DATA_OUT <= '0;
      HOST_DATA_OE  <= 1'b0;
    end else begin
      HOST_DATA_OE <= ci_d | di_d | di_m;
      if (ci_d) begin
        HOST_DATA_OUT <= status;
      end else if (di_d) begin
        HOST_DATA_OUT <= DISPLAY_READ_WORD;
      end else if (di_m) begin
        HOST_DATA_OUT <= MAPPER_READ_WORD;
      end else begin
        HOST_DATA_OUT <= '0;
      end
    end
  end

endmodule

// [bench/hio_port_sva.sv]
// Concurrent checks on the host I/O port pins.
module hio_port_sva
  import hio_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RESET_N,
  input wire logic [6:0]        DEVICE_SELECT_BITS,
  input wire logic [HIO_W-1:0]  HOST_DATA_IN,
  input wire logic [HIO_W-1:0]  HOST_DATA_OUT,
  input wire logic              HOST_DATA_OE,
  input wire logic              CONTROL_SET,
  input wire logic              STATUS_READ,
  input wire logic              INTERRUPT_LINE_ENABLE_N,
  input wire logic [PI_LINES:1] PI_REQ,
  input wire logic              SYSTEM_CLEAR,
  input wire logic              STEP,
  input wire logic              IO_STOP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic disp;
  assign disp = DEVICE_SELECT_BITS == DEV_DISPLAY;
  ////////////////////////////////////////
  // Strobes pass a pin synchroniser, so answers land a few edges later
  a_clear_pulse: assert property (
    $rose(CONTROL_SET) && disp && HOST_DATA_IN[17]
    |-> ##[1:4] SYSTEM_CLEAR ##1 !SYSTEM_CLEAR) else $error("no clear");
  a_step_pulse: assert property (
    $rose(CONTROL_SET) && disp && HOST_DATA_IN[5]
    |-> ##[1:4] STEP ##1 !STEP) else $error("no step");
  a_mapper_ignored: assert property (
    $rose(CONTROL_SET) && DEVICE_SELECT_BITS == DEV_MAPPER
    |=> !SYSTEM_CLEAR [*5]) else $error("mapper control acted");
  a_io_stop_set: assert property (
    $rose(CONTROL_SET) && disp && HOST_DATA_IN[11] && !HOST_DATA_IN[8]
    |-> ##[1:4] IO_STOP) else $error("io stop not set");
  a_pi_onehot: assert property ($onehot0(PI_REQ))
    else $error("two lines");
  a_pi_masked: assert property (
    INTERRUPT_LINE_ENABLE_N [*6] |=> PI_REQ == '0) else $error("unmasked");
  a_status_answer: assert property (
    $rose(STATUS_READ) && disp |-> ##[1:4] HOST_DATA_OE)
    else $error("no status");
  a_status_unused: assert property (
    STATUS_READ && $past(STATUS_READ) && disp && HOST_DATA_OE
    |-> HOST_DATA_OUT[31:18] == '0 && !HOST_DATA_OUT[12]
    && !HOST_DATA_OUT[4]) else $error("unused status bit set");
endmodule
bind hio_port hio_port_sva hio_port_sva_i (.CLK, .RESET_N,
  .DEVICE_SELECT_BITS, .HOST_DATA_IN, .HOST_DATA_OUT, .HOST_DATA_OE,
  .CONTROL_SET, .STATUS_READ, .INTERRUPT_LINE_ENABLE_N, .PI_REQ,
  .SYSTEM_CLEAR, .STEP, .IO_STOP);

// [bench/hio_host_model.sv]
// Behavioural host computer on the I/O bus.
module hio_host_model
  import hio_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic [HIO_W-1:0] HOST_DATA_OUT,
  input  wire logic             HOST_DATA_OE,
  output logic      [6:0]       DEVICE_SELECT_BITS,
  output logic      [HIO_W-1:0] HOST_DATA_IN,
  output logic      [5:0]       STROBES
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    DEVICE_SELECT_BITS = 7'h7F;
    HOST_DATA_IN = '0;
    STROBES = '0;
  end
  ////////////////////////////////////////
  // Strobe k: 0/1 data set/clear, 2/3 control set/clear, 4 data, 5 status
  task automatic xfer(input int k, input logic [6:0] dev,
                      input logic [HIO_W-1:0] wr,
                      output logic [HIO_W-1:0] rd);
    int n;
    rd = '0;
    @(negedge CLK);
    DEVICE_SELECT_BITS = dev;
    HOST_DATA_IN = wr;
    repeat (2) @(negedge CLK);
    STROBES[k] = 1'b1;
    for (n = 0; n < 8; n++) begin
      @(negedge CLK);
      if (k < 4 ? n == 3 : HOST_DATA_OE === 1'b1) break;
    end
    if (k >= 4 && HOST_DATA_OE === 1'b1) rd = HOST_DATA_OUT;
    STROBES = '0;
    // Released lines carry junk, never the last word
    DEVICE_SELECT_BITS = ~dev;
    HOST_DATA_IN = ~wr;
    repeat (5) @(negedge CLK);
  endtask
  // Sent twice so a clipper left in 3D mode is reset too
  task automatic sys_clear();
    logic [HIO_W-1:0] rd;
    repeat (2) xfer(2, DEV_DISPLAY, 36'h000020000, rd);
  endtask
endmodule

// [bench/test_hio_port.sv]
// Self-checking bench of the host I/O control and status port.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module test_hio_port
  import hio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst_n, irq_en_n, oe, clr, step, iostop, dstb, mstb;
  logic [6:0]        sel;
  logic [5:0]        stb;
  logic [3:0]        flags;
  logic [7:0]        ev;
  logic [PI_LINES:1] pi;
  logic [HIO_W-1:0]  din, dout, word, rd, rd_d, rd_m;
  int                miscompares = 0;
  int                checks = 0;
  int                n_clr = 0;
  int                n_step = 0;
  int                n_d = 0;
  int                n_m = 0;
  // Control word, then the whole status word it should leave behind
  logic [HIO_W-1:0]  rows [10][2] = '{
    '{36'h000010000, 36'h000008000}, '{36'h000002000, 36'h00000A000},
    '{36'h000000400, 36'h00000A400}, '{36'h000000800, 36'h00000A500},
    '{36'h00000000D, 36'h00000A505}, '{36'h000000006, 36'h00000A505},
    '{36'h000004010, 36'h00000A505}, '{36'h000009300, 36'h000000005},
    '{36'h000018000, 36'h000000005}, '{36'h000010000, 36'h000008005}};
  hio_port hio_port_i (.CLK(clk), .RESET_N(rst_n),
    .DEVICE_SELECT_BITS(sel), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout),
    .HOST_DATA_OE(oe), .DATAO_SET(stb[0]), .DATAO_CLR(stb[1]),
    .CONTROL_SET(stb[2]), .CONTROL_CLR(stb[3]), .DATAI(stb[4]),
    .STATUS_READ(stb[5]),
    .INTERRUPT_LINE_ENABLE_N(irq_en_n), .PI_REQ(pi), .DATA_WORD(word),
    .DISPLAY_DATA_STB(dstb), .MAPPER_DATA_STB(mstb),
    .DISPLAY_READ_WORD(rd_d), .MAPPER_READ_WORD(rd_m),
    .SYSTEM_CLEAR(clr), .STEP(step), .IO_STOP(iostop),
    .PROGRAM_FLAGS(flags), .PARITY_ERROR(ev[0]), .NONEXISTENT_MEMORY(ev[1]),
    .MAP_VIOLATION(ev[2]), .STOPPED_READY(ev[3]), .MM_STOP(ev[4]),
    .PROGRAM_STOP(ev[5]), .HIT(ev[6]), .SCOPE_VIOLATION(ev[7]));
  hio_host_model hio_host_model_i (.CLK(clk), .HOST_DATA_OUT(dout),
    .HOST_DATA_OE(oe), .DEVICE_SELECT_BITS(sel), .HOST_DATA_IN(din),
    .STROBES(stb));
  ////////////////////////////////////////
  task automatic op(input int k, input logic [6:0] dev,
                    input logic [HIO_W-1:0] w);
    hio_host_model_i.xfer(k, dev, w, rd);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    n_clr += clr;
    n_step += step;
    n_d += dstb;
    n_m += mstb;
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    irq_en_n = 1'b1;
    flags = '0;
    ev = '0;
    rd_d = 36'hA5A5A5A5A;
    rd_m = 36'h5A5A5A5A5;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    `CHK(pi, 7'h00)
    foreach (rows[i]) begin
      op(2, DEV_DISPLAY, rows[i][0]);
      op(5, DEV_DISPLAY, '0);
      `CHK(rd, rows[i][1])
      `CHK(iostop, rows[i][1][8])
    end
    // Alarm drives level 5 only while the lines are enabled
    irq_en_n = 1'b0;
    ev[0] = 1'b1;
    @(negedge clk);
    ev[0] = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(pi, 7'h10)
    op(5, DEV_DISPLAY, '0);
    `CHK(rd, 36'h00002800D)
    irq_en_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK(pi, 7'h00)
    hio_host_model_i.sys_clear();
    `CHK(n_clr, 2)
    op(5, DEV_DISPLAY, '0);
    `CHK(rd, 36'h000008005)
    // Every event at once, then only the live stop causes
    flags = 4'h9;
    ev = 8'hFF;
    @(negedge clk);
    ev = 8'h98;
    op(5, DEV_DISPLAY, '0);
    `CHK(rd, 36'h90003CAE5)
    op(2, DEV_DISPLAY, 36'h0000000E0);
    `CHK(n_step, 1)
    op(5, DEV_DISPLAY, '0);
    `CHK(rd, 36'h90003CA25)
    ev = '0;
    // Mapper takes data but no control, and has no status
    op(2, DEV_MAPPER, 36'h000020800);
    `CHK(iostop, 1'b0)
    `CHK(n_clr, 2)
    op(1, DEV_MAPPER, '0);
    op(0, DEV_MAPPER, 36'h123456789);
    `CHK(word, 36'h123456789)
    `CHK(n_d, 0)
    `CHK(n_m, 1)
    op(4, DEV_MAPPER, '0);
    `CHK(rd, rd_m)
    op(4, DEV_DISPLAY, '0);
    `CHK(rd, rd_d)
    op(5, DEV_MAPPER, '0);
    `CHK(rd, 36'h000000000)
    // Control clear strobe acts on nothing; data set ORs into the word
    op(3, DEV_DISPLAY, 36'h000020800);
    `CHK(iostop, 1'b0)
    `CHK(n_clr, 2)
    op(0, DEV_DISPLAY, 36'h800000001);
    `CHK(word, 36'h923456789)
    `CHK(n_d, 1)
    op(1, DEV_DISPLAY, '0);
    `CHK(word, 36'h000000000)
    // Violation still latched: map interrupt on level 6, then stop path
    op(2, DEV_DISPLAY, 36'h00000A00E);
    irq_en_n = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(pi, 7'h20)
    ev[3] = 1'b1;
    op(2, DEV_DISPLAY, 36'h000001C00);
    `CHK(pi, 7'h20)
    `CHK(iostop, 1'b1)
    op(5, DEV_DISPLAY, '0);
    `CHK(rd, 36'h900034D0E)
    // Mid-run reset drops enables, level, stop and sticky causes
    ev = '0;
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    `CHK(pi, 7'h00)
    `CHK(iostop, 1'b0)
    op(5, DEV_DISPLAY, '0);
    `CHK(rd, 36'h900000000)
    conclude();
  end
endmodule
